// [logic/tps_pkg.sv]
// shared constants and types for the serial test port pin logic
package tps_pkg;

    // tap controller states, one-hot
    typedef enum logic [15:0] {
        ST_RESET      = 16'h0001,
        ST_IDLE       = 16'h0002,
        ST_SEL_DR     = 16'h0004,
        ST_CAP_DR     = 16'h0008,
        ST_SHIFT_DR   = 16'h0010,
        ST_EXIT1_DR   = 16'h0020,
        ST_PAUSE_DR   = 16'h0040,
        ST_EXIT2_DR   = 16'h0080,
        ST_UPD_DR     = 16'h0100,
        ST_SEL_IR     = 16'h0200,
        ST_CAP_IR     = 16'h0400,
        ST_SHIFT_IR   = 16'h0800,
        ST_EXIT1_IR   = 16'h1000,
        ST_PAUSE_IR   = 16'h2000,
        ST_EXIT2_IR   = 16'h4000,
        ST_UPD_IR     = 16'h8000
    } tps_state_t;

    localparam int         IR_W        = 4;
    localparam int         DR_W        = 8;
    localparam int         FIFO_DEPTH  = 8;
    localparam logic [3:0] IR_CAPTURE  = 4'h1;
    localparam logic [3:0] IR_BYPASS   = 4'hf;
    localparam logic [3:0] IR_PUSH     = 4'h2;
    localparam logic [3:0] IR_RESET    = 4'hf;

    // one driven pad: output level and output enable
    typedef struct packed {
        logic o;
        logic oe;
    } tps_pad_t;

    typedef logic [DR_W-1:0] tps_word_t;

endpackage

// [logic/tps_test_port.sv]
// serial test port pins: tap controller, data path, pin function select, word fifo
//
// Operation
// - test data input captured into shift path on rising test clock edges in Shift-IR or Shift-DR.
// - test data output is a three-state pad with separate output enable.
// - test data output driven only in Shift-IR or Shift-DR states.
// - test data output updates on falling test clock edge.
// - after reset the line-zero pin serves as test data input.
// - after reset the line-one pin serves as test data output.
// - general-purpose use needs both peripheral enable and pin select set.
// - tap state machine steps from mode select sampled on rising edges.
`timescale 1ns/10ps
`default_nettype none

module tps_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] s_data,
    input  wire logic             s_valid,
    output logic                  s_ready,
    output logic [WIDTH-1:0]      m_data,
    output logic                  m_valid,
    input  wire logic             m_ready
);
    // one word waits in the output register, the rest in the array
    localparam int MD = DEPTH - 1;
    localparam int AW = $clog2(MD);
    logic [WIDTH-1:0] mem [MD];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic             out_valid_reg;
    logic             push;
    logic             pop;
    logic             load;
    // array full from its count; m_data and m_valid come straight from flops
    assign s_ready = (count_reg != (AW+1)'(MD));
    assign push    = s_valid && s_ready;
    assign load    = !out_valid_reg || m_ready; // output register free this cycle
    assign pop     = (count_reg != '0) && load;
    assign m_data  = out_data_reg;
    assign m_valid = out_valid_reg;
    // storage has no reset; a stale word is never shown with valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= s_data;
        end
        if (pop) begin
            out_data_reg <= mem[rd_ptr_reg];
        end
    end
    // pointers, occupancy and the output valid flag
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_ptr_reg    <= '0;
            rd_ptr_reg    <= '0;
            count_reg     <= '0;
            out_valid_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(MD-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(MD-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg     <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
            out_valid_reg <= pop || (out_valid_reg && !m_ready);
        end
    end
endmodule

module tps_test_port (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               port_d_line_zero_i,
    output tps_pkg::tps_pad_t       port_d_line_zero_pad,
    input  wire logic               port_d_line_one_i,
    output tps_pkg::tps_pad_t       port_d_line_one_pad,
    output tps_pkg::tps_pad_t       tdo_pad,
    input  wire logic [1:0]         port_peripheral_enable,
    input  wire logic [1:0]         peripheral_pin_select,
    input  wire logic [1:0]         gpio_out,
    input  wire logic [1:0]         gpio_oe,
    output logic [1:0]              gpio_in,
    output logic [1:0]              gpio_mode,
    output tps_pkg::tps_word_t      word_data,
    output logic                    word_valid,
    input  wire logic               word_ready
);
    // system clock domain state
    logic [1:0]         gpio_mode_reg;
    logic [1:0]         gpio_mode_next;
    logic [1:0]         gin_s1_reg;
    logic [1:0]         gin_s2_reg;
    logic [1:0]         gin_reg;
    tps_pkg::tps_pad_t  pad0_reg;
    tps_pkg::tps_pad_t  pad1_reg;
    logic               req_s1_reg;
    logic               req_s2_reg;
    logic               ack_reg;
    logic               fifo_s_ready;
    logic               fifo_push;
    tps_pkg::tps_word_t fifo_m_data;
    logic               fifo_m_valid;
    // test clock domain state
    tps_pkg::tps_state_t state_reg;
    tps_pkg::tps_state_t state_next;
    logic [3:0]          ir_shift_reg;
    logic [3:0]          ir_reg;
    tps_pkg::tps_word_t  dr_shift_reg;
    logic                byp_reg;
    tps_pkg::tps_word_t  hold_reg;
    logic                req_reg;
    logic                ack_s1_reg;
    logic                ack_s2_reg;
    logic [1:0]          mode_s1_reg;
    logic [1:0]          mode_s2_reg;
    tps_pkg::tps_pad_t   tdo_reg;
    logic                tdi_eff;
    logic                push_ready;
    logic                in_shift;
    logic                sel_push;
    logic                tdo_bit;
    // both controls must be set before a pin leaves its test role
    assign gpio_mode_next = port_peripheral_enable & peripheral_pin_select;
    // mode select from system logic; reset value keeps both test functions
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gpio_mode_reg <= 2'h0;
        end else begin
            gpio_mode_reg <= gpio_mode_next;
        end
    end
    // pad inputs come from outside the domain, two flops first
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gin_s1_reg <= 2'h0;
            gin_s2_reg <= 2'h0;
            gin_reg    <= 2'h0;
        end else begin
            gin_s1_reg <= {port_d_line_one_i, port_d_line_zero_i};
            gin_s2_reg <= gin_s1_reg;
            gin_reg    <= gin_s2_reg;
        end
    end
    // general-purpose drive only when that pin is handed over
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pad0_reg <= '0;
            pad1_reg <= '0;
        end else begin
            pad0_reg <= '{o: gpio_out[0], oe: gpio_mode_next[0] && gpio_oe[0]};
            pad1_reg <= '{o: gpio_out[1], oe: gpio_mode_next[1] && gpio_oe[1]};
        end
    end
    // toggle handshake receiver; a pending word waits for fifo space
    assign fifo_push = (req_s2_reg != ack_reg) && fifo_s_ready;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            ack_reg    <= 1'b0;
        end else begin
            req_s1_reg <= req_reg;
            req_s2_reg <= req_s1_reg;
            if (fifo_push) begin
                ack_reg <= req_s2_reg;
            end
        end
    end
    tps_fifo #(
        .WIDTH (tps_pkg::DR_W),
        .DEPTH (tps_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk     (clk),
        .reset   (reset),
        .s_data  (hold_reg),
        .s_valid (req_s2_reg != ack_reg),
        .s_ready (fifo_s_ready),
        .m_data  (fifo_m_data),
        .m_valid (fifo_m_valid),
        .m_ready (word_ready)
    );
    assign port_d_line_zero_pad = pad0_reg;
    assign port_d_line_one_pad  = pad1_reg;
    assign gpio_in              = gin_reg;
    assign gpio_mode            = gpio_mode_reg;
    assign word_data            = fifo_m_data;
    assign word_valid           = fifo_m_valid;
    // pin handed to general use feeds a constant one, as an idle probe would
    assign tdi_eff    = mode_s2_reg[0] ? 1'b1 : port_d_line_zero_i;
    assign push_ready = (ack_s2_reg == req_reg);
    assign in_shift   = (state_reg == tps_pkg::ST_SHIFT_IR) ||
                        (state_reg == tps_pkg::ST_SHIFT_DR);
    assign sel_push   = (ir_reg == tps_pkg::IR_PUSH);
    assign tdo_bit    = (state_reg == tps_pkg::ST_SHIFT_IR) ? ir_shift_reg[0] :
                        sel_push ? dr_shift_reg[0] : byp_reg;
    // next state from mode select
    always_comb begin
        case (state_reg)
            tps_pkg::ST_RESET:    state_next = tms ? tps_pkg::ST_RESET   : tps_pkg::ST_IDLE;
            tps_pkg::ST_IDLE:     state_next = tms ? tps_pkg::ST_SEL_DR  : tps_pkg::ST_IDLE;
            tps_pkg::ST_SEL_DR:   state_next = tms ? tps_pkg::ST_SEL_IR  : tps_pkg::ST_CAP_DR;
            tps_pkg::ST_CAP_DR:   state_next = tms ? tps_pkg::ST_EXIT1_DR : tps_pkg::ST_SHIFT_DR;
            tps_pkg::ST_SHIFT_DR: state_next = tms ? tps_pkg::ST_EXIT1_DR : tps_pkg::ST_SHIFT_DR;
            tps_pkg::ST_EXIT1_DR: state_next = tms ? tps_pkg::ST_UPD_DR  : tps_pkg::ST_PAUSE_DR;
            tps_pkg::ST_PAUSE_DR: state_next = tms ? tps_pkg::ST_EXIT2_DR : tps_pkg::ST_PAUSE_DR;
            tps_pkg::ST_EXIT2_DR: state_next = tms ? tps_pkg::ST_UPD_DR  : tps_pkg::ST_SHIFT_DR;
            tps_pkg::ST_UPD_DR:   state_next = tms ? tps_pkg::ST_SEL_DR  : tps_pkg::ST_IDLE;
            tps_pkg::ST_SEL_IR:   state_next = tms ? tps_pkg::ST_RESET   : tps_pkg::ST_CAP_IR;
            tps_pkg::ST_CAP_IR:   state_next = tms ? tps_pkg::ST_EXIT1_IR : tps_pkg::ST_SHIFT_IR;
            tps_pkg::ST_SHIFT_IR: state_next = tms ? tps_pkg::ST_EXIT1_IR : tps_pkg::ST_SHIFT_IR;
            tps_pkg::ST_EXIT1_IR: state_next = tms ? tps_pkg::ST_UPD_IR  : tps_pkg::ST_PAUSE_IR;
            tps_pkg::ST_PAUSE_IR: state_next = tms ? tps_pkg::ST_EXIT2_IR : tps_pkg::ST_PAUSE_IR;
            tps_pkg::ST_EXIT2_IR: state_next = tms ? tps_pkg::ST_UPD_IR  : tps_pkg::ST_SHIFT_IR;
            tps_pkg::ST_UPD_IR:   state_next = tms ? tps_pkg::ST_SEL_DR  : tps_pkg::ST_IDLE;
            default:              state_next = tps_pkg::ST_RESET;
        endcase
    end
    // state register, stepped on rising test clock
    always_ff @(posedge tck or posedge reset) begin
        if (reset) begin
            state_reg <= tps_pkg::ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end
    // instruction path: capture, shift in at msb, update
    always_ff @(posedge tck or posedge reset) begin
        if (reset) begin
            ir_shift_reg <= 4'h0;
            ir_reg       <= tps_pkg::IR_RESET;
        end else if (state_reg == tps_pkg::ST_RESET) begin
            ir_reg <= tps_pkg::IR_RESET;
        end else if (state_reg == tps_pkg::ST_CAP_IR) begin
            ir_shift_reg <= tps_pkg::IR_CAPTURE;
        end else if (state_reg == tps_pkg::ST_SHIFT_IR) begin
            ir_shift_reg <= {tdi_eff, ir_shift_reg[3:1]};
        end else if (state_reg == tps_pkg::ST_UPD_IR) begin
            ir_reg <= ir_shift_reg;
        end
    end
    // data path; capture reports whether the last word has been taken
    always_ff @(posedge tck or posedge reset) begin
        if (reset) begin
            dr_shift_reg <= 8'h00;
            byp_reg      <= 1'b0;
        end else if (state_reg == tps_pkg::ST_CAP_DR) begin
            dr_shift_reg <= {7'h00, push_ready};
            byp_reg      <= 1'b0;
        end else if (state_reg == tps_pkg::ST_SHIFT_DR) begin
            dr_shift_reg <= {tdi_eff, dr_shift_reg[7:1]};
            byp_reg      <= tdi_eff;
        end
    end
    // word launch; dropped if the previous one is still in flight
    always_ff @(posedge tck or posedge reset) begin
        if (reset) begin
            hold_reg <= 8'h00;
            req_reg  <= 1'b0;
        end else if (state_reg == tps_pkg::ST_UPD_DR && sel_push && push_ready) begin
            hold_reg <= dr_shift_reg;
            req_reg  <= ~req_reg;
        end
    end
    // acknowledge and pin mode enter the test clock domain
    always_ff @(posedge tck or posedge reset) begin
        if (reset) begin
            ack_s1_reg  <= 1'b0;
            ack_s2_reg  <= 1'b0;
            mode_s1_reg <= 2'h0;
            mode_s2_reg <= 2'h0;
        end else begin
            ack_s1_reg  <= ack_reg;
            ack_s2_reg  <= ack_s1_reg;
            mode_s1_reg <= gpio_mode_reg;
            mode_s2_reg <= mode_s1_reg;
        end
    end
    // falling edge launch gives the probe half a period of setup
    always_ff @(negedge tck or posedge reset) begin
        if (reset) begin
            tdo_reg <= '0;
        end else begin
            tdo_reg <= '{o: tdo_bit, oe: in_shift && !mode_s2_reg[1]};
        end
    end
    assign tdo_pad = tdo_reg;

endmodule

`default_nettype wire

// [sim/tps_test_port_monitor.sv]
// assertion checker for the serial test port pins
`timescale 1ns/10ps
`default_nettype none
module tps_test_port_monitor (
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              tck,
    input wire logic              port_d_line_zero_i,
    input wire logic              port_d_line_one_i,
    input wire tps_pkg::tps_pad_t port_d_line_zero_pad,
    input wire tps_pkg::tps_pad_t port_d_line_one_pad,
    input wire tps_pkg::tps_pad_t tdo_pad,
    input wire logic [1:0]        port_peripheral_enable,
    input wire logic [1:0]        peripheral_pin_select,
    input wire logic [1:0]        gpio_out,
    input wire logic [1:0]        gpio_oe,
    input wire logic [1:0]        gpio_in,
    input wire logic [1:0]        gpio_mode,
    input wire tps_pkg::tps_word_t word_data,
    input wire logic              word_valid,
    input wire logic              word_ready
);
    // helper nets, so that $past only ever sees a plain signal
    wire logic [1:0] pad_lvl  = {port_d_line_one_i, port_d_line_zero_i};
    wire logic [1:0] sel_both = port_peripheral_enable & peripheral_pin_select;
    wire logic [1:0] g0 = {gpio_out[0], gpio_oe[0]};
    wire logic [1:0] g1 = {gpio_out[1], gpio_oe[1]};
    // a word offered but not yet taken
    sequence s_held;
        word_valid && !word_ready;
    endsequence
    // tck low for 80 ns, so a clk edge sees it low after a falling-edge update
    a_tdo_on_fall: assert property (@(posedge clk) disable iff (reset)
        $changed(tdo_pad) |-> !tck) else $error("tdo moved with tck high");
    a_mode_both: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) |-> gpio_mode == $past(sel_both)) else $error("gpio role wrong");
    a_pad_zero: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) |-> (gpio_mode[0] ? port_d_line_zero_pad == $past(g0)
        : !port_d_line_zero_pad.oe)) else $error("line zero pad wrong");
    a_pad_one: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) |-> (gpio_mode[1] ? port_d_line_one_pad == $past(g1)
        : !port_d_line_one_pad.oe)) else $error("line one pad wrong");
    a_tdo_off_gpio: assert property (@(posedge tck) disable iff (reset)
        gpio_mode[1] [*4] |-> !tdo_pad.oe) else $error("tdo driven in gpio role");
    a_valid_holds: assert property (@(posedge clk) disable iff (reset)
        s_held |=> word_valid && $stable(word_data)) else $error("word dropped");
    a_reset_quiet: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> gpio_mode == 2'h0 && !word_valid && !tdo_pad.oe
        && !port_d_line_zero_pad.oe && !port_d_line_one_pad.oe) else $error("reset state");
    a_gpio_in_lag: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) && !$past(reset, 2) && !$past(reset, 3) |-> gpio_in == $past(pad_lvl, 3))
        else $error("gpio input lag wrong");
endmodule
bind tps_test_port tps_test_port_monitor u_mon (
    .clk                    (clk),
    .reset                  (reset),
    .tck                    (tck),
    .port_d_line_zero_i     (port_d_line_zero_i),
    .port_d_line_one_i      (port_d_line_one_i),
    .port_d_line_zero_pad   (port_d_line_zero_pad),
    .port_d_line_one_pad    (port_d_line_one_pad),
    .tdo_pad                (tdo_pad),
    .port_peripheral_enable (port_peripheral_enable),
    .peripheral_pin_select  (peripheral_pin_select),
    .gpio_out               (gpio_out),
    .gpio_oe                (gpio_oe),
    .gpio_in                (gpio_in),
    .gpio_mode              (gpio_mode),
    .word_data              (word_data),
    .word_valid             (word_valid),
    .word_ready             (word_ready)
);
`default_nettype wire

// [sim/tps_probe_model.sv]
// behavioural debug probe driving the test clock, mode select and data in
`timescale 1ns/10ps
`default_nettype none
module tps_probe_model (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      tdi_en,
    input wire logic  tdo_line
);
    // clock stands low between frames; data line left to its pull-up until the first step
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        tdi_en = 1'b0;
    end
    // one 160 ns test clock; levels set while low, output taken at the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        tdi_en = 1'b1;
        #80 tck = 1'b1;
        q = tdo_line;
        #80 tck = 1'b0;
    endtask
endmodule
`default_nettype wire

// [sim/tps_test_port_test.sv]
// self-checking bench for the serial test port pins
`timescale 1ns/10ps
`default_nettype none
module tps_test_port_test;
    logic               clk = 1'b0;
    logic               reset = 1'b1;
    logic [1:0]         en = 2'h0;
    logic [1:0]         sel = 2'h0;
    logic [1:0]         g_out = 2'h0;
    logic [1:0]         g_oe = 2'h0;
    logic               word_ready = 1'b0;
    logic               last1 = 1'b0;
    logic               pend = 1'b0;
    logic [7:0]         pw = 8'h00;
    wire logic          tck, tms, tdi, tdi_en, word_valid;
    wire logic [1:0]    g_in, g_mode;
    tps_pkg::tps_word_t word_data;
    tps_pkg::tps_pad_t  pad0, pad1, tdo_pad;
    int                 n_errors = 0;
    int                 n_tests = 0;
    int                 seed = 62;
    int                 exp_q[$];
    // released line one shows the inverse of its last level, line zero pulls up
    wire logic line1 = tdo_pad.oe ? tdo_pad.o : pad1.oe ? pad1.o : ~last1;
    wire logic line0 = pad0.oe ? pad0.o : tdi_en ? tdi : 1'b1;
    always #25 clk = ~clk;
    always @(posedge clk) if (tdo_pad.oe | pad1.oe) last1 <= line1;
    tps_test_port u_dut (.clk(clk), .reset(reset), .tck(tck), .tms(tms),
        .port_d_line_zero_i(line0), .port_d_line_zero_pad(pad0), .port_d_line_one_i(line1),
        .port_d_line_one_pad(pad1), .tdo_pad(tdo_pad), .port_peripheral_enable(en),
        .peripheral_pin_select(sel), .gpio_out(g_out), .gpio_oe(g_oe), .gpio_in(g_in),
        .gpio_mode(g_mode), .word_data(word_data), .word_valid(word_valid),
        .word_ready(word_ready));
    tps_probe_model u_probe (.tck(tck), .tms(tms), .tdi(tdi), .tdi_en(tdi_en),
        .tdo_line(line1));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // idle steps let acknowledges cross, then one IR or DR scan, back to idle
    task automatic frame(input logic ir, input int nb, input logic [7:0] din,
                         output logic [7:0] dout);
        logic q;
        int i;
        repeat (4) u_probe.step(1'b0, 1'b1, q);
        u_probe.step(1'b1, 1'b1, q);
        if (ir) u_probe.step(1'b1, 1'b1, q);
        u_probe.step(1'b0, 1'b1, q);
        u_probe.step(1'b0, 1'b1, q);
        dout = 8'h00;
        for (i = 0; i < nb; i++) begin
            u_probe.step(i == nb - 1, din[i], q);
            dout[i] = q;
        end
        u_probe.step(1'b1, 1'b1, q);
        u_probe.step(1'b0, 1'b1, q);
    endtask
    // model: word taken only when the last one was acknowledged
    task automatic push(input logic [7:0] w);
        logic [7:0] d;
        frame(1'b0, 8, w, d);
        check("ready bit", d, {7'h0, !pend});
        if (!pend && exp_q.size() < tps_pkg::FIFO_DEPTH) exp_q.push_back(w);
        else if (!pend) begin
            pend = 1'b1;
            pw = w;
        end
    endtask
    // far side takes words with random stalls; pending word refills the fifo
    task automatic drain();
        int n;
        for (n = 0; n < 400 && exp_q.size() > 0; n++) begin
            @(posedge clk);
            #2;
            word_ready = 1'($random(seed));
            if (word_valid === 1'b1 && word_ready) begin
                check("word", word_data, 8'(exp_q.pop_front()));
                if (pend) exp_q.push_back(pw);
                pend = 1'b0;
            end
        end
        if (exp_q.size() > 0) n_errors++;
        if (exp_q.size() > 0) report_and_stop();
        @(posedge clk);
        #2;
        word_ready = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        check("valid", word_valid, 8'h00);
        $display("drain test done");
    endtask
    initial begin
        logic [7:0] d;
        int k;
        repeat (16) @(posedge clk);
        #2;
        reset = 1'b0;
        @(posedge clk);
        #2;
        check("gpio role", g_mode, 8'h00);
        check("pad oe", {pad0.oe, pad1.oe, tdo_pad.oe}, 8'h00);
        $display("reset test done");
        for (k = 0; k < 16; k++) begin
            en = 2'(k);
            sel = 2'(k >> 2);
            g_out = 2'($random(seed));
            g_oe = 2'h3;
            repeat (4) @(posedge clk);
            #2;
            check("gpio role", g_mode, en & sel);
            check("gpio in", g_in & en & sel, g_out & en & sel);
        end
        // both pins handed over: a scan must leave the line-one pin to the port
        g_out = 2'h3;
        frame(1'b0, 2, 8'h00, d);
        check("tdo in gpio role", d & 8'h03, 8'h03);
        repeat (5) u_probe.step(1'b1, 1'b1, d[0]);
        @(posedge clk);
        #2;
        en = 2'h0;
        sel = 2'h0;
        $display("gpio test done");
        frame(1'b1, 4, tps_pkg::IR_PUSH, d);
        check("ir capture", d & 8'h0f, 8'h01);
        for (k = 0; k < 10; k++) push(8'($random(seed)));
        drain();
        push(8'($random(seed)));
        drain();
        repeat (5) u_probe.step(1'b1, 1'b1, d[0]);
        frame(1'b0, 2, 8'h03, d);
        check("bypass", d & 8'h03, 8'h02);
        @(posedge clk);
        #2;
        check("tdo oe idle", tdo_pad.oe, 8'h00);
        $display("scan test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
